/* File: hdl/voice_store_spi_command_status.sv */
// Serial command interpreter and status reporter of a voice store device.
// Assumes the host drives the serial clock idle high, keeps it still while
// select is high, and waits three core clocks after select falls.
//
// Function
// - Priority commands are taken whatever the busy state, except a stop during erase, which sets error.
// - Command bit 4 enables the indicator lamp; host sets it when wanted.
// - Any row, including the sound effect rows, may be addressed by number.
// - Equal start and end rows operate on that one row only.
// - Ranged erase wipes start row through end row inclusive.
// - Ranged record runs start to end and marks end of message at end row.
// - Ranged play runs from start row and halts at end row.
// - One same-type ranged command may wait behind the running one.
// - A different ranged type while ranged is active is refused with error.
// - Secondary status ready flag shows when a queued command fits.
// - Interrupt indication rises when a ranged operation finishes while the done flag is clear.
// - Queued play skips the stop at an end marker and continues.
// - Circular commands act like push-button ones, never sound effects.
// - Broken layout at push-button start flashes the indicator seven times.
// - Every response opens with the 16-bit primary status word.
// - Status bits 0-4 error, full, powered, marker, done; row above.
// - Done flag sets on completion, stays until flag clear command.
// - End-of-message flag sets on a found marker, flag clear clears it.
// - Powered flag reads 1 while powered up and in serial mode.
// - Memory full flag reports that no new message can be recorded.
// - Error flag marks short ranged address or ignored command.
// - Response bits leave on falling serial clock, least bit first.
// - While busy, only the allowed set is taken; others set error.
// - During ranged work ready reads 1 only with empty pending slot.
`timescale 1ns/1ps
`default_nettype none

module voice_store_spi_command_status #(
	parameter int FLASH_CYCLES = voice_store_pkg::FLASH_CYCLES
) (
	// Core clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	// Serial port from the host
	input  wire logic        link_sclk_i,
	input  wire logic        ss_n_i,
	input  wire logic        mosi_i,
	output logic             miso_o,
	// Mode pin, high for serial operation
	input  wire logic        serial_mode_i,
	// Memory array
	input  wire logic        eom_found_i,
	input  wire logic        mem_full_i,
	input  wire logic        layout_bad_i,
	output logic [10:0]      mem_row_o,
	output logic [2:0]       mem_op_o,
	output logic             eom_write_o,
	// Indicators
	output logic             led_o,
	output logic             int_o
);

	localparam logic [24:0] FLASH_LAST = 25'(FLASH_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////
	// Link domain.

	logic [5:0]  bit_cnt_reg;
	logic [55:0] rx_reg;
	logic [2:0]  nbytes_reg;
	logic        tx_started_reg;
	logic [55:0] tx_reg;
	logic [55:0] snap_reg;
	logic [6:0]  nb_w;

	always_ff @(posedge link_sclk_i or posedge ss_n_i) begin
		if (ss_n_i) begin
			bit_cnt_reg <= 6'h00;
		end else if (bit_cnt_reg != voice_store_pkg::FRAME_BITS) begin
			bit_cnt_reg <= bit_cnt_reg + 6'h01;
		end
	end

	// Frame contents are not reset so they survive the end of the frame.
	// full row access
	always_ff @(posedge link_sclk_i) begin
		if (bit_cnt_reg < voice_store_pkg::FRAME_BITS) begin
			rx_reg[bit_cnt_reg] <= mosi_i;
		end
	end

	assign nb_w = ({1'b0, bit_cnt_reg} + 7'h01) >> 3;

	always_ff @(posedge link_sclk_i) begin
		nbytes_reg <= nb_w[2:0];
	end

	always_ff @(negedge link_sclk_i or posedge ss_n_i) begin
		if (ss_n_i) begin
			tx_started_reg <= 1'b0;
		end else begin
			tx_started_reg <= 1'b1;
		end
	end

	// The snapshot is frozen by the core while select is low, so sampling
	// it here on the first falling edge is safe.
	// falling edge shift
	always_ff @(negedge link_sclk_i) begin
		if (tx_started_reg) begin
			tx_reg <= {1'b0, tx_reg[55:1]};
		end else begin
			tx_reg <= {1'b0, snap_reg[55:1]};
		end
	end

	always_ff @(negedge link_sclk_i or posedge ss_n_i) begin
		if (ss_n_i) begin
			miso_o <= 1'b0;
		end else if (tx_started_reg) begin
			miso_o <= tx_reg[0];
		end else begin
			miso_o <= snap_reg[0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core domain: synchronisers and decode.

	logic ss_s1_reg;
	logic ss_s2_reg;
	logic ss_s3_reg;
	logic mode_s1_reg;
	logic mode_s2_reg;
	logic mode_s3_reg;
	logic frame_end_w;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ss_s1_reg <= 1'b1;
			ss_s2_reg <= 1'b1;
			ss_s3_reg <= 1'b1;
			mode_s1_reg <= 1'b0;
			mode_s2_reg <= 1'b0;
			mode_s3_reg <= 1'b0;
		end else begin
			ss_s1_reg <= ss_n_i;
			ss_s2_reg <= ss_s1_reg;
			ss_s3_reg <= ss_s2_reg;
			mode_s1_reg <= serial_mode_i;
			mode_s2_reg <= mode_s1_reg;
			mode_s3_reg <= mode_s2_reg;
		end
	end

	assign frame_end_w = ss_s2_reg & ~ss_s3_reg;

	voice_store_pkg::frame_t    cmd_w;
	voice_store_pkg::op_state_t state_reg;
	logic [7:0]  opc_w;
	logic [2:0]  new_kind_w;
	logic [10:0] end_row_reg;
	logic [11:0] timer_reg;
	logic        pend_reg;
	logic [10:0] pend_start_reg;
	logic [10:0] pend_end_reg;
	logic        pu_reg;
	logic        err_reg;
	logic        eom_reg;
	logic        done_reg;
	logic        led_en_reg;
	logic        busy_w;
	logic        do_pu;
	logic        do_pd;
	logic        do_reset;
	logic        do_clear;
	logic        do_stop;
	logic        do_start_rng;
	logic        do_queue;
	logic        do_start_circ;
	logic        do_skip;
	logic        cmd_err_w;

	assign cmd_w.opcode = rx_reg[voice_store_pkg::OPC_LSB +: 8];
	assign cmd_w.start_row = rx_reg[voice_store_pkg::START_LSB +: 11];
	assign cmd_w.end_row = rx_reg[voice_store_pkg::END_LSB +: 11];
	assign cmd_w.nbytes = nbytes_reg;
	assign opc_w = cmd_w.opcode & ~voice_store_pkg::LED_MASK;
	assign busy_w = (state_reg != voice_store_pkg::ST_IDLE);

	always_comb begin
		do_pu = 1'b0;
		do_pd = 1'b0;
		do_reset = 1'b0;
		do_clear = 1'b0;
		do_stop = 1'b0;
		do_start_rng = 1'b0;
		do_queue = 1'b0;
		do_start_circ = 1'b0;
		do_skip = 1'b0;
		cmd_err_w = 1'b0;
		new_kind_w = voice_store_pkg::KIND_NONE;
		if (frame_end_w && mode_s2_reg) begin
			case (opc_w)
				voice_store_pkg::OPC_POWER_UP: do_pu = 1'b1;
				voice_store_pkg::OPC_POWER_DOWN: do_pd = 1'b1;
				voice_store_pkg::OPC_RESET: do_reset = 1'b1;
				voice_store_pkg::OPC_FLAG_CLEAR: do_clear = 1'b1;
				voice_store_pkg::OPC_STATUS_READ,
				voice_store_pkg::OPC_IDENT_READ: begin
				end
				// stop only for record or play
				voice_store_pkg::OPC_STOP: begin
					if (mem_op_o[voice_store_pkg::KB_ERASE]) begin
						cmd_err_w = 1'b1;
					end else begin
						do_stop = busy_w;
					end
				end
				voice_store_pkg::OPC_PLAY,
				voice_store_pkg::OPC_REC,
				voice_store_pkg::OPC_ERASE: begin
					new_kind_w = (opc_w == voice_store_pkg::OPC_PLAY) ?
						voice_store_pkg::KIND_PLAY :
						(opc_w == voice_store_pkg::OPC_REC) ?
						voice_store_pkg::KIND_REC :
						voice_store_pkg::KIND_ERASE;
					cmd_err_w = !pu_reg || busy_w;
					do_start_circ = !cmd_err_w;
				end
				voice_store_pkg::OPC_SKIP_AHEAD: begin
					cmd_err_w = !pu_reg || busy_w;
					do_skip = !cmd_err_w;
				end
				voice_store_pkg::OPC_RANGED_PLAY,
				voice_store_pkg::OPC_RANGED_REC,
				voice_store_pkg::OPC_RANGED_ERASE: begin
					new_kind_w = (opc_w == voice_store_pkg::OPC_RANGED_PLAY) ?
						voice_store_pkg::KIND_PLAY :
						(opc_w == voice_store_pkg::OPC_RANGED_REC) ?
						voice_store_pkg::KIND_REC :
						voice_store_pkg::KIND_ERASE;
					if (!pu_reg || cmd_w.nbytes < voice_store_pkg::RANGED_BYTES) begin
						cmd_err_w = 1'b1;
					end else if (!busy_w) begin
						do_start_rng = 1'b1;
					end else if (state_reg == voice_store_pkg::ST_RANGED &&
						new_kind_w == mem_op_o && !pend_reg) begin
						do_queue = 1'b1;
					end else begin
						cmd_err_w = 1'b1;
					end
				end
				default: cmd_err_w = 1'b1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core domain: row engine.

	logic tick_w;
	logic rng_end_w;
	logic play_eom_w;
	logic circ_full_w;
	logic circ_erase_w;
	logic finish_w;
	logic chain_w;

	assign tick_w = busy_w && (timer_reg == 12'h000);
	assign rng_end_w = tick_w && state_reg == voice_store_pkg::ST_RANGED &&
		mem_row_o == end_row_reg;
	assign play_eom_w = tick_w && mem_op_o[voice_store_pkg::KB_PLAY] &&
		eom_found_i && !rng_end_w;
	assign circ_full_w = tick_w && state_reg == voice_store_pkg::ST_CIRC &&
		mem_op_o[voice_store_pkg::KB_REC] && mem_full_i;
	assign circ_erase_w = tick_w && state_reg == voice_store_pkg::ST_CIRC &&
		mem_op_o[voice_store_pkg::KB_ERASE];
	assign finish_w = rng_end_w | play_eom_w | circ_full_w | circ_erase_w;
	assign chain_w = pend_reg && (rng_end_w ||
		(play_eom_w && state_reg == voice_store_pkg::ST_RANGED));

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= voice_store_pkg::ST_IDLE;
			mem_op_o <= voice_store_pkg::KIND_NONE;
			mem_row_o <= 11'h000;
			end_row_reg <= 11'h000;
			timer_reg <= 12'h000;
		end else if (do_reset) begin
			state_reg <= voice_store_pkg::ST_IDLE;
			mem_op_o <= voice_store_pkg::KIND_NONE;
			mem_row_o <= 11'h000;
		end else if (do_pd || do_stop || (finish_w && !chain_w)) begin
			state_reg <= voice_store_pkg::ST_IDLE;
			mem_op_o <= voice_store_pkg::KIND_NONE;
		end else if (do_start_rng) begin
			state_reg <= voice_store_pkg::ST_RANGED;
			mem_op_o <= new_kind_w;
			mem_row_o <= cmd_w.start_row;
			end_row_reg <= cmd_w.end_row;
			timer_reg <= voice_store_pkg::ROW_LAST;
		end else if (do_start_circ) begin
			state_reg <= voice_store_pkg::ST_CIRC;
			mem_op_o <= new_kind_w;
			timer_reg <= voice_store_pkg::ROW_LAST;
		end else if (do_skip) begin
			mem_row_o <= mem_row_o + 11'h001;
		end else if (chain_w) begin
			mem_row_o <= pend_start_reg;
			end_row_reg <= pend_end_reg;
			timer_reg <= voice_store_pkg::ROW_LAST;
		end else if (tick_w) begin
			mem_row_o <= mem_row_o + 11'h001;
			timer_reg <= voice_store_pkg::ROW_LAST;
		end else if (busy_w) begin
			timer_reg <= timer_reg - 12'h001;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pend_reg <= 1'b0;
			pend_start_reg <= 11'h000;
			pend_end_reg <= 11'h000;
		end else if (do_reset || do_pd || do_stop || chain_w) begin
			pend_reg <= 1'b0;
		end else if (do_queue) begin
			pend_reg <= 1'b1;
			pend_start_reg <= cmd_w.start_row;
			pend_end_reg <= cmd_w.end_row;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			eom_write_o <= 1'b0;
		end else begin
			eom_write_o <= mem_op_o[voice_store_pkg::KB_REC] &&
				(rng_end_w || do_stop || circ_full_w);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core domain: flags, status words and indicators.

	// A completion in the same cycle as a flag clear keeps the flag set.
	// sticky done
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			done_reg <= 1'b0;
		end else if (finish_w || do_stop) begin
			done_reg <= 1'b1;
		end else if (do_clear) begin
			done_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			eom_reg <= 1'b0;
		end else if (play_eom_w) begin
			eom_reg <= 1'b1;
		end else if (do_clear) begin
			eom_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			err_reg <= 1'b0;
			led_en_reg <= 1'b0;
		end else if (frame_end_w && mode_s2_reg) begin
			err_reg <= cmd_err_w;
			led_en_reg <= cmd_w.opcode[voice_store_pkg::LED_BIT];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pu_reg <= 1'b0;
		end else if (do_pu) begin
			pu_reg <= 1'b1;
		end else if (do_pd) begin
			pu_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			int_o <= 1'b0;
		end else begin
			int_o <= done_reg;
		end
	end

	voice_store_pkg::primary_status_word_t sr0_w;
	logic [7:0] sr1_w;
	logic       rdy_w;

	assign sr0_w.row = mem_row_o;
	assign sr0_w.done = done_reg;
	assign sr0_w.end_of_message_marker = eom_reg;
	assign sr0_w.pu = pu_reg & mode_s2_reg;
	assign sr0_w.full = mem_full_i;
	assign sr0_w.err = err_reg;

	assign rdy_w = (state_reg == voice_store_pkg::ST_IDLE) ||
		(state_reg == voice_store_pkg::ST_RANGED && !pend_reg);
	assign sr1_w = {4'h0, mem_op_o[voice_store_pkg::KB_REC],
		mem_op_o[voice_store_pkg::KB_PLAY],
		mem_op_o[voice_store_pkg::KB_ERASE], rdy_w};

	// Frozen while select is low so the link domain sees a stable word.
	// status leads response
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			snap_reg <= 56'h00_0000_0000_0000;
		end else if (ss_s2_reg) begin
			snap_reg <= {sr0_w[7:0], sr0_w, 8'h00, sr1_w, sr0_w};
		end
	end

	logic [3:0]  flash_cnt_reg;
	logic [24:0] flash_tmr_reg;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			flash_cnt_reg <= 4'h0;
			flash_tmr_reg <= 25'h000_0000;
			led_o <= 1'b0;
		end else if (!mode_s2_reg && mode_s3_reg && layout_bad_i) begin
			flash_cnt_reg <= voice_store_pkg::FLASH_PHASES;
			flash_tmr_reg <= FLASH_LAST;
			led_o <= 1'b1;
		end else if (flash_cnt_reg != 4'h0) begin
			if (flash_tmr_reg == 25'h000_0000) begin
				flash_cnt_reg <= flash_cnt_reg - 4'h1;
				flash_tmr_reg <= FLASH_LAST;
				led_o <= ~led_o;
			end else begin
				flash_tmr_reg <= flash_tmr_reg - 25'h000_0001;
			end
		end else begin
			led_o <= led_en_reg && busy_w;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	property p_stop_any_time;
		do_stop |=> state_reg == voice_store_pkg::ST_IDLE && !pend_reg;
	endproperty
	a_stop_any_time: assert property (p_stop_any_time)
		else $error("stop did not end the operation");

	property p_other_type_refused;
		frame_end_w && state_reg == voice_store_pkg::ST_RANGED &&
		new_kind_w != voice_store_pkg::KIND_NONE && new_kind_w != mem_op_o
		|=> err_reg && $stable(pend_reg);
	endproperty
	a_other_type_refused: assert property (p_other_type_refused)
		else $error("different ranged type was not refused");

	property p_queue_fill;
		do_queue |=> pend_reg && !rdy_w;
	endproperty
	a_queue_fill: assert property (p_queue_fill)
		else $error("queued ranged command not held");

	property p_ready_slot;
		state_reg == voice_store_pkg::ST_RANGED |-> sr1_w[0] == !pend_reg;
	endproperty
	a_ready_slot: assert property (p_ready_slot)
		else $error("ready flag disagrees with pending slot");

	property p_done_sticky;
		done_reg && !do_clear |=> done_reg;
	endproperty
	a_done_sticky: assert property (p_done_sticky)
		else $error("done flag dropped without flag clear");

	property p_int_follows;
		rng_end_w && !chain_w |=> done_reg ##1 int_o;
	endproperty
	a_int_follows: assert property (p_int_follows)
		else $error("finished range gave no interrupt");

	property p_rec_marker;
		rng_end_w && mem_op_o[voice_store_pkg::KB_REC] |=> eom_write_o;
	endproperty
	a_rec_marker: assert property (p_rec_marker)
		else $error("ranged record wrote no end marker");

	property p_end_row_stops;
		rng_end_w && !pend_reg && !do_reset && !do_pd
		|=> state_reg == voice_store_pkg::ST_IDLE &&
		mem_op_o == voice_store_pkg::KIND_NONE;
	endproperty
	a_end_row_stops: assert property (p_end_row_stops)
		else $error("ranged operation ran past end row");

	property p_short_address;
		frame_end_w && mode_s2_reg &&
		(opc_w == voice_store_pkg::OPC_RANGED_PLAY ||
		opc_w == voice_store_pkg::OPC_RANGED_REC ||
		opc_w == voice_store_pkg::OPC_RANGED_ERASE) &&
		cmd_w.nbytes < voice_store_pkg::RANGED_BYTES |=> err_reg;
	endproperty
	a_short_address: assert property (p_short_address)
		else $error("short ranged command not flagged");

	property p_chain_play;
		chain_w && play_eom_w |=> mem_op_o == voice_store_pkg::KIND_PLAY &&
		mem_row_o == $past(pend_start_reg);
	endproperty
	a_chain_play: assert property (p_chain_play)
		else $error("queued play did not follow the end marker");

endmodule

`default_nettype wire

/* File: hdl/voice_store_pkg.sv */
// Shared constants and carriers for the voice store serial command block.
// Assumes a 125 MHz core clock; the serial clock comes from the host.
package voice_store_pkg;

	// Core clock and row timing.
	localparam int CLK_PERIOD_NS = 8;
	localparam int ROW_TIME_NS = 32000;
	localparam int ROW_CYCLES = ROW_TIME_NS / CLK_PERIOD_NS;
	localparam logic [11:0] ROW_LAST = 12'(ROW_CYCLES - 1);

	// Indicator flash timing for a broken circular layout.
	localparam int FLASH_TIME_NS = 200000000;
	localparam int FLASH_CYCLES = FLASH_TIME_NS / CLK_PERIOD_NS;
	localparam int FLASH_COUNT = 7;
	localparam logic [3:0] FLASH_PHASES = 4'(2 * FLASH_COUNT - 1);

	// Frame layout, least significant bit first on both data lines.
	localparam int ROW_W = 11;
	localparam logic [5:0] FRAME_BITS = 6'h38;
	localparam int OPC_LSB = 0;
	localparam int START_LSB = 16;
	localparam int END_LSB = 32;
	localparam int LED_BIT = 4;
	localparam logic [2:0] RANGED_BYTES = 3'h7;
	localparam logic [7:0] LED_MASK = 8'h10;

	// Opcodes, compared with the indicator bit masked off.
	localparam logic [7:0] OPC_POWER_UP = 8'h01;
	localparam logic [7:0] OPC_STOP = 8'h02;
	localparam logic [7:0] OPC_RESET = 8'h03;
	localparam logic [7:0] OPC_FLAG_CLEAR = 8'h04;
	localparam logic [7:0] OPC_STATUS_READ = 8'h05;
	localparam logic [7:0] OPC_POWER_DOWN = 8'h07;
	localparam logic [7:0] OPC_IDENT_READ = 8'h09;
	localparam logic [7:0] OPC_PLAY = 8'h40;
	localparam logic [7:0] OPC_REC = 8'h41;
	localparam logic [7:0] OPC_ERASE = 8'h42;
	localparam logic [7:0] OPC_SKIP_AHEAD = 8'h48;
	localparam logic [7:0] OPC_RANGED_PLAY = 8'h80;
	localparam logic [7:0] OPC_RANGED_REC = 8'h81;
	localparam logic [7:0] OPC_RANGED_ERASE = 8'h82;

	// One-hot operation kind, also the memory operation output.
	localparam int KB_PLAY = 0;
	localparam int KB_REC = 1;
	localparam int KB_ERASE = 2;
	localparam logic [2:0] KIND_NONE = 3'h0;
	localparam logic [2:0] KIND_PLAY = 3'h1;
	localparam logic [2:0] KIND_REC = 3'h2;
	localparam logic [2:0] KIND_ERASE = 3'h4;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RANGED,
		ST_CIRC
	} op_state_t;

	// Decoded command frame.
	typedef struct packed {
		logic [ROW_W-1:0] end_row;
		logic [ROW_W-1:0] start_row;
		logic [7:0]       opcode;
		logic [2:0]       nbytes;
	} frame_t;

	// Primary status word; err lands in bit 0, row in bits 15:5.
	typedef struct packed {
		logic [ROW_W-1:0] row;
		logic             done;
		logic             end_of_message_marker;
		logic             pu;
		logic             full;
		logic             err;
	} primary_status_word_t;

endpackage

/* File: sim/voice_host_model.sv */
// Host microcontroller model: serial port master of the voice store.
// Assumes the device drives on falling and samples on rising serial clock.
`timescale 1ns/1ps
`default_nettype none

module voice_host_model (
	// Serial port to the device
	output logic             link_sclk_o,
	output logic             ss_n_o,
	output logic             mosi_o,
	input  wire logic        miso_i
);
	initial begin
		link_sclk_o = 1'b1;
		ss_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// The serial clock stands high between frames, as the device expects.
	// seven byte ranged frames
	task automatic xfer(input logic [55:0] tx, input int nbits,
		output logic [55:0] rx);
		rx = '0;
		ss_n_o = 1'b0;
		#43;
		for (int i = 0; i < nbits; i++) begin
			link_sclk_o = 1'b0;
			mosi_o = tx[i];
			#80;
			link_sclk_o = 1'b1;
			rx[i] = miso_i;
			#80;
		end
		mosi_o = 1'b0;
		ss_n_o = 1'b1;
		#160;
	endtask
endmodule

`default_nettype wire

/* File: sim/tb_voice_store_spi_command_status.sv */
// Testbench of the voice store serial command block.
// Assumes the host model frames commands; the bench plays the memory array.
`timescale 1ns/1ps
`default_nettype none

module tb_voice_store_spi_command_status;
	logic        ref_clk_i = 1'b0;
	logic        rst_n_i, serial_mode_i, eom_found_i, mem_full_i;
	logic        layout_bad_i;
	wire         link_sclk, ss_n, mosi, miso_o, eom_write_o, led_o, int_o;
	wire  [10:0] mem_row_o;
	wire  [2:0]  mem_op_o;
	logic [55:0] rx;
	int          num_errors, tests_run, n;

	always #4 ref_clk_i = ~ref_clk_i;

	voice_host_model host (.link_sclk_o(link_sclk), .ss_n_o(ss_n),
		.mosi_o(mosi), .miso_i(miso_o));

	voice_store_spi_command_status #(.FLASH_CYCLES(8)) DUT (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link_sclk_i(link_sclk),
		.ss_n_i(ss_n), .mosi_i(mosi), .miso_o(miso_o),
		.serial_mode_i(serial_mode_i), .eom_found_i(eom_found_i),
		.mem_full_i(mem_full_i), .layout_bad_i(layout_bad_i),
		.mem_row_o(mem_row_o), .mem_op_o(mem_op_o),
		.eom_write_o(eom_write_o), .led_o(led_o), .int_o(int_o));

	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic send(input logic [7:0] opc, input logic [10:0] s, e);
		host.xfer({8'h00, 5'h00, e, 5'h00, s, 8'h00, opc}, 56, rx);
	endtask

	// Status read; flags are {done, eom, powered, full, error}.
	task automatic stat(input logic [10:0] row, input logic [4:0] f,
		input logic [15:0] m);
		send(voice_store_pkg::OPC_STATUS_READ, 11'h000, 11'h000);
		chk(rx[15:0] & m, {row, f} & m);
		chk(rx[47:32] & m, {row, f} & m);
		chk({8'h00, rx[55:48]} & m, {8'h00, row[2:0], f} & m);
	endtask

	// Waits for an operation on a row; a gap to idle fails when nogap.
	task automatic wait_op(input logic [2:0] k, input logic [10:0] r,
		input logic [10:0] rm, input bit nogap);
		n = 0;
		while (!(mem_op_o === k && (mem_row_o & rm) === (r & rm))) begin
			@(negedge ref_clk_i);
			n++;
			if (n > 9000 || (nogap && mem_op_o === 3'h0)) begin
				num_errors++;
				$display("BAD t=%0t op=%h exp=%h", $time, mem_op_o, k);
				report_and_stop();
			end
		end
		chk({2'b00, mem_op_o, mem_row_o & rm}, {2'b00, k, r & rm});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		num_errors = 0;
		tests_run = 0;
		rst_n_i = 1'b0;
		serial_mode_i = 1'b1;
		eom_found_i = 1'b0;
		mem_full_i = 1'b0;
		layout_bad_i = 1'b0;
		repeat (8) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		stat(11'h000, 5'b00000, 16'hFFFF);
		send(voice_store_pkg::OPC_RANGED_PLAY, 11'h005, 11'h005);
		stat(11'h000, 5'b00001, 16'hFFFF);
		send(voice_store_pkg::OPC_POWER_UP, 11'h000, 11'h000);
		stat(11'h000, 5'b00100, 16'hFFFF);
		$display("test reset and power up done");
		mem_full_i <= 1'b1;
		send(voice_store_pkg::OPC_RANGED_PLAY | 8'h10, 11'h005, 11'h005);
		wait_op(voice_store_pkg::KIND_PLAY, 11'h005, 11'h7FF, 0);
		chk({15'h0, led_o}, 16'h0001);
		wait_op(voice_store_pkg::KIND_NONE, 11'h000, 11'h000, 0);
		repeat (2) @(negedge ref_clk_i);
		chk({15'h0, int_o}, 16'h0001);
		stat(11'h000, 5'b10110, 16'h001F);
		mem_full_i <= 1'b0;
		send(voice_store_pkg::OPC_FLAG_CLEAR, 11'h000, 11'h000);
		stat(11'h000, 5'b00100, 16'h001F);
		chk({15'h0, int_o}, 16'h0000);
		$display("test single row play done");
		eom_found_i <= 1'b1;
		send(voice_store_pkg::OPC_RANGED_PLAY, 11'h006, 11'h007);
		wait_op(voice_store_pkg::KIND_PLAY, 11'h006, 11'h7FF, 0);
		send(voice_store_pkg::OPC_RANGED_PLAY, 11'h008, 11'h008);
		stat(11'h006, 5'b00100, 16'hFFFF);
		chk({15'h0, rx[16]}, 16'h0000);
		wait_op(voice_store_pkg::KIND_PLAY, 11'h008, 11'h7FF, 1);
		eom_found_i <= 1'b0;
		wait_op(voice_store_pkg::KIND_NONE, 11'h000, 11'h000, 0);
		stat(11'h000, 5'b11100, 16'h001F);
		$display("test chained play done");
		send(voice_store_pkg::OPC_FLAG_CLEAR, 11'h000, 11'h000);
		send(voice_store_pkg::OPC_RANGED_REC, 11'h003, 11'h004);
		wait_op(voice_store_pkg::KIND_REC, 11'h003, 11'h7FF, 0);
		send(voice_store_pkg::OPC_RANGED_ERASE, 11'h009, 11'h009);
		stat(11'h003, 5'b00101, 16'hFFFF);
		n = 0;
		while (eom_write_o !== 1'b1 && n < 9000) begin
			@(negedge ref_clk_i);
			n++;
		end
		chk({5'h0, eom_write_o, mem_row_o}, {5'h0, 1'b1, 11'h004});
		if (n >= 9000)
			report_and_stop();
		wait_op(voice_store_pkg::KIND_NONE, 11'h000, 11'h000, 0);
		send(voice_store_pkg::OPC_RANGED_REC, 11'h010, 11'h012);
		wait_op(voice_store_pkg::KIND_REC, 11'h010, 11'h7FF, 0);
		send(voice_store_pkg::OPC_STOP, 11'h000, 11'h000);
		wait_op(voice_store_pkg::KIND_NONE, 11'h000, 11'h000, 0);
		$display("test ranged record done");
		send(voice_store_pkg::OPC_RANGED_ERASE, 11'h00A, 11'h00C);
		wait_op(voice_store_pkg::KIND_ERASE, 11'h00A, 11'h7FF, 0);
		wait_op(voice_store_pkg::KIND_ERASE, 11'h00B, 11'h7FF, 1);
		wait_op(voice_store_pkg::KIND_ERASE, 11'h00C, 11'h7FF, 1);
		wait_op(voice_store_pkg::KIND_NONE, 11'h000, 11'h000, 0);
		host.xfer({48'h0, voice_store_pkg::OPC_RANGED_ERASE}, 16, rx);
		stat(11'h000, 5'b00001, 16'h0001);
		$display("test erase and short frame done");
		send(voice_store_pkg::OPC_RESET, 11'h000, 11'h000);
		stat(11'h000, 5'b10100, 16'hFFFF);
		layout_bad_i <= 1'b1;
		serial_mode_i <= 1'b0;
		n = 0;
		repeat (400) begin
			@(negedge ref_clk_i);
			if (led_o === 1'b1 && rx[0] !== 1'b1)
				n++;
			rx[0] = led_o;
		end
		chk(16'(n), 16'h0007);
		$display("test layout flash done");
		report_and_stop();
	end
endmodule

`default_nettype wire
